// ---- bench/adc_model.sv ----
/*
  Behavioural ADC facing the power monitor: one sample set per request,
  answering alternately at once and a few cycles late.
  Assumes requests are one-cycle pulses on clk with at most one outstanding.
*/
`timescale 1ns/10ps
module adc_model #(
  parameter [11:0] VIN = 12'h800,
  parameter [11:0] VOUT = 12'h600,
  parameter [11:0] IOUT = 12'h400,
  parameter [11:0] TEMP = 12'h300
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // request and answer
  input wire adc_request,
  output reg adc_valid,
  output wire [11:0] adc_vin,
  output wire [11:0] adc_vout,
  output wire [11:0] adc_iout,
  output wire [11:0] adc_temp
);
  reg busy_reg;
  reg slow_reg;
  reg [2:0] wait_reg;

  // slow and prompt answers alternate so both paths of the design are used
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_reg <= 1'b0;
      slow_reg <= 1'b0;
      wait_reg <= 3'h0;
      adc_valid <= 1'b0;
    end
    else
    begin
      adc_valid <= 1'b0;
      if (adc_request && !busy_reg)
      begin
        busy_reg <= 1'b1;
        wait_reg <= slow_reg ? 3'h5 : 3'h0;
        slow_reg <= !slow_reg;
      end
      else if (busy_reg && wait_reg != 3'h0)
        wait_reg <= wait_reg - 3'h1;
      else if (busy_reg)
      begin
        busy_reg <= 1'b0;
        adc_valid <= 1'b1;
      end
    end
  end

  // outside a valid cycle the data lines show the inverse, never a stale value
  assign adc_vin = adc_valid ? VIN : ~VIN;
  assign adc_vout = adc_valid ? VOUT : ~VOUT;
  assign adc_iout = adc_valid ? IOUT : ~IOUT;
  assign adc_temp = adc_valid ? TEMP : ~TEMP;
endmodule

// ---- bench/power_monitor_sva_chk_sva.sv ----
/*
  Port checker for the power monitor register bank.
  Assumes a single clk domain and is bound to every power_monitor.
*/
`timescale 1ns/10ps
module power_monitor_sva (
  // clock and reset
  input wire clk,
  input wire nrst,
  // command port
  input wire [7:0] cmd_code,
  input wire wr_strobe,
  input wire [15:0] wr_data,
  input wire rd_start,
  input wire rd_next,
  input wire status_clear,
  input wire [7:0] rd_data_reg,
  input wire [3:0] rd_len_reg,
  // adc, faults and pin
  input wire adc_request_reg,
  input wire overtemperature_fault,
  input wire timed_overcurrent_fault,
  input wire pass_transistor_health_fault,
  input wire input_undervoltage_fault,
  input wire input_overvoltage_fault,
  input wire [1:0] output_pin_one_function,
  input wire alert_output_one_oe_reg
);
  // any of the five fault pulses; health, overcurrent and OV ones re-arm the sticky alert flags
  wire any_fault = overtemperature_fault | timed_overcurrent_fault |
    pass_transistor_health_fault | input_undervoltage_fault | input_overvoltage_fault;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  a_revision_value: assert property (
    rd_start && cmd_code == 8'h98 |=> rd_data_reg == 8'h33 && rd_len_reg == 4'h1)
    else $error("revision byte wrong");
  a_energy_length: assert property (
    rd_start && cmd_code == 8'h86 |=> rd_len_reg == 4'h6)
    else $error("energy length wrong");
  a_string_length: assert property (
    rd_start && cmd_code == 8'h9A |=> rd_len_reg == 4'h7)
    else $error("model string length wrong");
  a_run_reserved: assert property (
    rd_start && cmd_code == 8'hD3 |=> rd_data_reg[7:1] == 7'h00)
    else $error("run control reserved bits set");
  a_read_holds: assert property (
    !rd_start && !rd_next |=> $stable(rd_data_reg) && $stable(rd_len_reg))
    else $error("read byte changed without request");
  a_stop_request: assert property (
    (wr_strobe && cmd_code == 8'hD3 && !wr_data[0] && output_pin_one_function != 2'h2)
    ##1 !(wr_strobe && cmd_code == 8'hD3) |=> !adc_request_reg [*3])
    else $error("request after stop");
  a_reset_run: assert property (
    $rose(nrst) |-> ##[0:1] adc_request_reg)
    else $error("no sampling after reset");
  a_clear_alert: assert property (
    status_clear && !any_fault ##1 !any_fault |=> !alert_output_one_oe_reg)
    else $error("alert held after clear");
  a_alert_mode: assert property (
    $rose(alert_output_one_oe_reg) |-> $past(output_pin_one_function) != 2'h2)
    else $error("alert driven on trigger pin");
endmodule

bind power_monitor power_monitor_sva chk_u (.clk(clk), .nrst(nrst), .cmd_code(cmd_code),
  .wr_strobe(wr_strobe), .wr_data(wr_data), .rd_start(rd_start), .rd_next(rd_next),
  .status_clear(status_clear), .rd_data_reg(rd_data_reg), .rd_len_reg(rd_len_reg),
  .adc_request_reg(adc_request_reg), .overtemperature_fault(overtemperature_fault),
  .timed_overcurrent_fault(timed_overcurrent_fault),
  .pass_transistor_health_fault(pass_transistor_health_fault),
  .input_undervoltage_fault(input_undervoltage_fault),
  .input_overvoltage_fault(input_overvoltage_fault),
  .output_pin_one_function(output_pin_one_function),
  .alert_output_one_oe_reg(alert_output_one_oe_reg));

// ---- bench/tb.sv ----
/*
  Self-checking bench for the power monitor register bank.
  Assumes the ADC model on the far side; inputs change on the falling edge.
*/
`timescale 1ns/10ps
module tb;
  localparam [31:0] MAKER = 32'h5A595857; // arbitrary identity value
  localparam [55:0] MODEL = 56'h11223344556677; // arbitrary identity value
  localparam [15:0] HWREV = 16'h5152; // arbitrary identity value
  localparam [11:0] VIN = 12'h800;
  localparam [11:0] IOUT = 12'h400;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic wr_strobe = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  logic rd_start = 1'b0;
  logic rd_next = 1'b0;
  logic status_clear = 1'b0;
  logic [4:0] flt = 5'h00;
  logic [1:0] out_fn = 2'h0;
  logic trig = 1'b0;
  wire [7:0] rd_data_reg;
  wire [3:0] rd_len_reg;
  wire adc_request_reg, adc_valid, alert_output_one_n_reg, alert_output_one_oe_reg;
  wire [11:0] adc_vin, adc_vout, adc_iout, adc_temp;
  logic [3:0] len_seen;
  logic [55:0] v;
  logic [67:0] rows [0:14];
  logic [2:0] codes [0:4] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;

  power_monitor #(.MAKER_ID(MAKER), .MODEL_ID(MODEL), .HW_REV_ID(HWREV)) dut_u (
    .clk(clk), .nrst(nrst), .cmd_code(cmd_code), .wr_strobe(wr_strobe),
    .wr_data(wr_data), .rd_start(rd_start), .rd_next(rd_next),
    .status_clear(status_clear), .rd_data_reg(rd_data_reg), .rd_len_reg(rd_len_reg),
    .adc_request_reg(adc_request_reg), .adc_valid(adc_valid), .adc_vin(adc_vin),
    .adc_vout(adc_vout), .adc_iout(adc_iout), .adc_temp(adc_temp),
    .overtemperature_fault(flt[0]), .timed_overcurrent_fault(flt[1]),
    .pass_transistor_health_fault(flt[2]), .input_undervoltage_fault(flt[3]),
    .input_overvoltage_fault(flt[4]), .output_pin_one_function(out_fn),
    .sample_trigger_input(trig), .alert_output_one_n_reg(alert_output_one_n_reg),
    .alert_output_one_oe_reg(alert_output_one_oe_reg));

  adc_model #(.VIN(VIN), .IOUT(IOUT)) adc_u (.clk(clk), .nrst(nrst),
    .adc_request(adc_request_reg), .adc_valid(adc_valid), .adc_vin(adc_vin),
    .adc_vout(adc_vout), .adc_iout(adc_iout), .adc_temp(adc_temp));

  // 40 MHz clock
  always #12.5 clk = !clk;

  // hang guard, generous against the few thousand cycles really needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      test_done;
    end
  end

  task chk(input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk);
    cmd_code = c;
    wr_data = d;
    wr_strobe = 1'b1;
    @(negedge clk);
    wr_strobe = 1'b0;
  endtask

  // bytes arrive low first; rd_next stays up across a back-to-back burst
  task rd(input logic [7:0] c, input int n, output logic [55:0] r);
    r = '0;
    @(negedge clk);
    cmd_code = c;
    rd_start = 1'b1;
    @(negedge clk);
    rd_start = 1'b0;
    rd_next = (n > 1);
    len_seen = rd_len_reg;
    r[7:0] = rd_data_reg;
    for (int i = 1; i < n; i++)
    begin
      @(negedge clk);
      r[8*i +: 8] = rd_data_reg;
      rd_next = (i < n - 1);
    end
  endtask

  task rc(input logic [7:0] c, input int n, input logic [55:0] e);
    rd(c, n, v);
    chk(v, e);
  endtask

  task poll(input logic [7:0] c, input int n, input logic [55:0] e);
    for (int t = 0; t < 300; t++)
    begin
      rd(c, n, v);
      if (v === e)
        break;
      repeat (20) @(negedge clk);
    end
    chk(v, e);
  endtask

  task test_done;
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // main sequence: table of readbacks first, awkward cases after
  initial
  begin
    rows[0] = {8'h98, 4'h1, 56'h33};
    rows[1] = {8'h99, 4'h4, 24'h0, MAKER};
    rows[2] = {8'h9A, 4'h7, MODEL};
    rows[3] = {8'h9B, 4'h2, 40'h0, HWREV};
    rows[4] = {8'h88, 4'h2, 44'h0, VIN};
    rows[5] = {8'h8C, 4'h2, 44'h0, IOUT};
    rows[6] = {8'h97, 4'h2, 56'h2000};
    rows[7] = {8'h8B, 4'h2, 56'h0};
    rows[8] = {8'h8D, 4'h2, 56'h0};
    rows[9] = {8'hD3, 4'h1, 56'h1};
    rows[10] = {8'hD4, 4'h2, 56'h0714};
    rows[11] = {8'hD5, 4'h2, 56'h0};
    rows[12] = {8'hD0, 4'h2, 44'h0, IOUT};
    rows[13] = {8'hD1, 4'h2, 44'h0, VIN};
    rows[14] = {8'h81, 4'h0, 56'h0};
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    poll(8'h88, 2, {44'h0, VIN});
    for (int r = 0; r < 15; r++)
    begin
      rd(rows[r][67:60], int'(rows[r][59:56]), v);
      chk(len_seen, rows[r][59:56]);
      chk(v, rows[r][55:0]);
    end
    // snapshot fields must agree: each sample adds 0x2000 to the accumulator
    rd(8'h86, 6, v);
    chk(v[47:24] != 24'h0, 1'b1);
    chk(v[15:0], {v[34:24], 5'h00});
    chk(v[23:16], v[42:35]);
    // continuous mode only stops on a host write of zero
    wr(8'hD3, 16'h0000);
    repeat (30) @(negedge clk);
    rc(8'hD3, 1, 56'h0);
    wr(8'hD1, 16'h0123);
    rc(8'hD1, 2, {44'h0, VIN});
    wr(8'hD1, 16'h0000);
    rc(8'hD1, 2, 56'h0);
    for (int i = 0; i < 8; i++)
    begin
      wr(8'hD4, {2'b11, i[2:0], i[2:0], 8'hFF});
      rc(8'hD4, 2, {2'b00, i[2:0], i[2:0], 8'h1E});
    end
    wr(8'hD5, 16'hFFFF);
    rc(8'hD5, 2, 56'hFFFE);
    wr(8'hD5, 16'hE000);
    for (int k = 0; k < 5; k++)
    begin
      @(negedge clk);
      flt = 5'h01 << k;
      @(negedge clk);
      flt = 5'h00;
      rc(8'h80, 1, codes[k]);
      repeat (2) @(negedge clk);
      chk(alert_output_one_oe_reg, k == 1 || k == 2 || k == 4);
      chk(alert_output_one_n_reg, 1'b0);
      status_clear = 1'b1;
      @(negedge clk);
      status_clear = 1'b0;
      repeat (2) @(negedge clk);
      chk(alert_output_one_oe_reg, 1'b0);
      rc(8'h80, 1, 56'h0);
    end
    wr(8'hD3, 16'h0001);
    rc(8'hD3, 1, 56'h1);
    wr(8'hD3, 16'h0000);
    wr(8'hD4, 16'h0704);
    trig = 1'b1;
    repeat (6) @(negedge clk);
    rc(8'hD3, 1, 56'h0);
    trig = 1'b0;
    out_fn = 2'h2;
    repeat (4) @(negedge clk);
    trig = 1'b1;
    repeat (6) @(negedge clk);
    rc(8'hD3, 1, 56'h1);
    poll(8'hD3, 1, 56'h0);
    test_done;
  end
endmodule

// ---- hw/power_monitor.v ----
/*
  Register bank and sampling control of a hot-swap power monitor: readings,
  peaks, energy, identity strings, run control, configuration, alert mask.
  Assumes a link layer on clk that delivers decoded commands, an ADC on clk
  that answers each request with one set of samples, and hot-swap logic that
  pulses one fault line per shutdown.
*/
`timescale 1ns/10ps
`include "power_monitor_regs.vh"

// Functional notes
// - Shutdown reason codes: 0 none, 1 temp, 2 overcurrent, 3 health, 4 UV, 6 OV.
// - Energy readout bits 47..24 hold the 24-bit sample count.
// - Energy readout bits 23..16 count reported energy wraps.
// - Accumulator is 24 bits; only its upper 16 bits are reported.
// - Input voltage reading is 12 bits, upper nibble zero.
// - Output voltage, current, temperature readings likewise 12 bits, upper zero.
// - Power is per-sample voltage times current, averaged, reported 16 bits.
// - Protocol revision answers 0x33.
// - Read-only identity strings of 32, 56 and 16 bits.
// - Three 12-bit peaks; writing zero clears a peak.
// - Run bit resets to 1; single-shot clears it after one full cycle.
// - Trigger edge or write 1 sets run; edges while running ignored.
// - Power averaging field 13..11 selects 2^code samples, resets 0.
// - Voltage/current averaging field 10..8, same encoding, resets 7.
// - Bit 4 selects single-shot (0) or continuous (1), resets continuous.
// - Channel enables: temp bit 3, vin bit 2, vout bit 1; off means unsampled.
// - Alert mask bits 15, 14, 13 route health, overcurrent, OV faults to alert.
// - Reserved bits of control and configuration read zero.
// - Shutdown reason is a 3-bit latched field, held until status clear.
// - Trigger input works only when the shared pin mode is conversion input.
module power_monitor #(
  parameter [31:0] MAKER_ID = 32'h41424344, // arbitrary value
  parameter [55:0] MODEL_ID = 56'h4D4F44454C3031, // arbitrary value
  parameter [15:0] HW_REV_ID = 16'h4130 // arbitrary value
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // decoded command port from the link layer
  input wire [7:0] cmd_code,
  input wire wr_strobe,
  input wire [15:0] wr_data,
  input wire rd_start,
  input wire rd_next,
  input wire status_clear,
  output reg [7:0] rd_data_reg,
  output reg [3:0] rd_len_reg,
  // adc
  output reg adc_request_reg,
  input wire adc_valid,
  input wire [11:0] adc_vin,
  input wire [11:0] adc_vout,
  input wire [11:0] adc_iout,
  input wire [11:0] adc_temp,
  // hot-swap fault pulses
  input wire overtemperature_fault,
  input wire timed_overcurrent_fault,
  input wire pass_transistor_health_fault,
  input wire input_undervoltage_fault,
  input wire input_overvoltage_fault,
  // shared pin 13: alert out (open drain), trigger in
  input wire [1:0] output_pin_one_function,
  input wire sample_trigger_input,
  output reg alert_output_one_n_reg,
  output reg alert_output_one_oe_reg
);

  reg run_reg;
  reg [15:0] config_reg;
  reg [15:0] alert_mask_reg;
  reg [2:0] last_shutdown_reason_reg;
  reg health_flag_reg;
  reg oc_flag_reg;
  reg ov_flag_reg;
  reg [11:0] peak_current_reg;
  reg [11:0] peak_input_voltage_reg;
  reg [11:0] peak_output_voltage_reg;
  reg [23:0] energy_reg;
  reg [23:0] sample_count_reg;
  reg [7:0] energy_wrap_total_reg;
  reg [23:0] product_reg;
  reg product_valid_reg;
  reg pending_reg;
  reg cur_seen_reg;
  reg pwr_seen_reg;
  reg trig_meta_reg;
  reg trig_sync_reg;
  reg trig_prev_reg;
  reg [63:0] rd_shift_reg;
  reg [63:0] snap;
  reg [3:0] snap_len;
  wire [2:0] va_avg;
  wire [2:0] pw_avg;
  wire continuous;
  wire [3:0] ch_on;
  wire [47:0] ch_data;
  wire [47:0] ch_avg;
  wire [3:0] ch_done;
  wire [23:0] pw_avg_val;
  wire pwr_done;
  wire [24:0] energy_sum;
  wire trig_edge;
  wire start;
  wire cycle_end;
  wire run_write_one;
  wire run_write_zero;

  // averaging codes and mode from configuration
  assign va_avg = config_reg[`CFG_VA_AVG_HI:`CFG_VA_AVG_LO];
  assign pw_avg = config_reg[`CFG_PW_AVG_HI:`CFG_PW_AVG_LO];
  assign continuous = config_reg[`CFG_MODE_BIT];

  // per-channel enable; current has no enable and always samples
  assign ch_on = {config_reg[`CFG_TEMP_EN_BIT], 1'b1,
                  config_reg[`CFG_VOUT_ON_BIT], config_reg[`CFG_VIN_ON_BIT]};
  assign ch_data = {adc_temp, adc_iout, adc_vout, adc_vin};

  // channel order: 0 vin, 1 vout, 2 iout, 3 temp
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : chan
      sample_averager #(.W(12)) avg_u (
        .clk(clk),
        .nrst(nrst),
        .restart(start),
        .sel(va_avg),
        .in_valid(adc_valid & ch_on[g]),
        .in_data(ch_data[12*g+11:12*g]),
        .avg_reg(ch_avg[12*g+11:12*g]),
        .done_reg(ch_done[g])
      );
    end
  endgenerate

  // power averages per-sample products, not a product of means
  sample_averager #(.W(24)) pwr_u (
    .clk(clk),
    .nrst(nrst),
    .restart(start),
    .sel(pw_avg),
    .in_valid(product_valid_reg),
    .in_data(product_reg),
    .avg_reg(pw_avg_val),
    .done_reg(pwr_done)
  );

  // trigger pin passes two flops, only honoured in conversion-input mode
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      trig_meta_reg <= 1'b0;
      trig_sync_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end
    else
    begin
      trig_meta_reg <= sample_trigger_input;
      trig_sync_reg <= trig_meta_reg;
      trig_prev_reg <= trig_sync_reg;
    end
  end

  assign trig_edge = trig_sync_reg & ~trig_prev_reg
                     & (output_pin_one_function == `PIN_FN_TRIG);
  assign run_write_one = wr_strobe & (cmd_code == `OFF_RUN_CONTROL) & wr_data[0];
  assign run_write_zero = wr_strobe & (cmd_code == `OFF_RUN_CONTROL) & ~wr_data[0];
  // a start only from idle, so edges while sampling do nothing
  assign start = ~run_reg & (trig_edge | run_write_one);
  // full cycle: current window closed, and power window closed if it runs
  assign cycle_end = cur_seen_reg & (pwr_seen_reg | ~config_reg[`CFG_VIN_ON_BIT]);

  // run bit; a set request counts only from idle, so the single-shot self-clear wins over one in the same cycle
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      run_reg <= `RUN_RESET;
    else if (start)
      // set by edge or write of one
      run_reg <= 1'b1;
    else if (run_write_zero)
      // host stop, the only stop in continuous mode
      run_reg <= 1'b0;
    else if (run_reg & ~continuous & cycle_end)
      run_reg <= 1'b0;
  end

  // cycle tracking and adc requests, one outstanding at a time
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur_seen_reg <= 1'b0;
      pwr_seen_reg <= 1'b0;
      pending_reg <= 1'b0;
      adc_request_reg <= 1'b0;
    end
    else
    begin
      adc_request_reg <= run_reg & ~pending_reg & ~adc_request_reg & ~cycle_end;
      if (adc_request_reg)
        pending_reg <= 1'b1;
      else if (adc_valid)
        pending_reg <= 1'b0;
      if (start | ~run_reg)
      begin
        cur_seen_reg <= 1'b0;
        pwr_seen_reg <= 1'b0;
      end
      else if (cycle_end & continuous)
      begin
        // continuous mode starts the next cycle right away
        cur_seen_reg <= 1'b0;
        pwr_seen_reg <= 1'b0;
      end
      else
      begin
        if (ch_done[2])
          cur_seen_reg <= 1'b1;
        if (pwr_done)
          pwr_seen_reg <= 1'b1;
      end
    end
  end

  // product per sample, then energy and count per power sample
  assign energy_sum = {1'b0, energy_reg} + {9'h000, product_reg[23:8]};
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      product_reg <= 24'h000000;
      product_valid_reg <= 1'b0;
      energy_reg <= 24'h000000;
      sample_count_reg <= 24'h000000;
      energy_wrap_total_reg <= 8'h00;
    end
    else
    begin
      product_valid_reg <= adc_valid & config_reg[`CFG_VIN_ON_BIT];
      if (adc_valid)
        product_reg <= adc_vin * adc_iout;
      if (product_valid_reg)
      begin
        energy_reg <= energy_sum[23:0];
        sample_count_reg <= sample_count_reg + 24'h000001;
        // wrap of the accumulator is a wrap of its reported top bits
        if (energy_sum[24])
          energy_wrap_total_reg <= energy_wrap_total_reg + 8'h01;
      end
    end
  end

  // peaks; a new larger reading wins over a clearing write
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      peak_input_voltage_reg <= 12'h000;
      peak_output_voltage_reg <= 12'h000;
      peak_current_reg <= 12'h000;
    end
    else
    begin
      if (ch_done[0] & (ch_avg[11:0] > peak_input_voltage_reg))
        peak_input_voltage_reg <= ch_avg[11:0];
      else if (wr_strobe & (cmd_code == `OFF_PEAK_INPUT_VOLTAGE) & (wr_data == 16'h0000))
        peak_input_voltage_reg <= 12'h000;
      if (ch_done[1] & (ch_avg[23:12] > peak_output_voltage_reg))
        peak_output_voltage_reg <= ch_avg[23:12];
      else if (wr_strobe & (cmd_code == `OFF_PEAK_OUTPUT_VOLTAGE) & (wr_data == 16'h0000))
        peak_output_voltage_reg <= 12'h000;
      if (ch_done[2] & (ch_avg[35:24] > peak_current_reg))
        peak_current_reg <= ch_avg[35:24];
      else if (wr_strobe & (cmd_code == `OFF_PEAK_CURRENT) & (wr_data == 16'h0000))
        peak_current_reg <= 12'h000;
    end
  end

  // configuration and alert mask writes; reserved bits never stored
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      config_reg <= `CFG_RESET;
      alert_mask_reg <= `ALERT_RESET;
    end
    else if (wr_strobe)
    begin
      if (cmd_code == `OFF_MONITOR_CONFIG)
        config_reg <= wr_data & `CFG_WRITE_MASK;
      if (cmd_code == `OFF_ALERT_ONE_MASK)
        alert_mask_reg <= wr_data & `ALERT_WRITE_MASK;
    end
  end

  // shutdown reason and sticky faults; a new fault beats a status clear
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      last_shutdown_reason_reg <= `CAUSE_NONE;
      health_flag_reg <= 1'b0;
      oc_flag_reg <= 1'b0;
      ov_flag_reg <= 1'b0;
    end
    else
    begin
      // latch the code of the fault that shut the switch down
      if (overtemperature_fault)
        last_shutdown_reason_reg <= `CAUSE_OVERTEMP;
      else if (timed_overcurrent_fault)
        last_shutdown_reason_reg <= `CAUSE_OVERCURRENT;
      else if (pass_transistor_health_fault)
        last_shutdown_reason_reg <= `CAUSE_HEALTH;
      else if (input_undervoltage_fault)
        last_shutdown_reason_reg <= `CAUSE_UNDERVOLT;
      else if (input_overvoltage_fault)
        last_shutdown_reason_reg <= `CAUSE_OVERVOLT;
      else if (status_clear)
        last_shutdown_reason_reg <= `CAUSE_NONE;
      health_flag_reg <= pass_transistor_health_fault | (health_flag_reg & ~status_clear);
      oc_flag_reg <= timed_overcurrent_fault | (oc_flag_reg & ~status_clear);
      ov_flag_reg <= input_overvoltage_fault | (ov_flag_reg & ~status_clear);
    end
  end

  // masked faults pull the alert low; pin released when used as input
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      alert_output_one_n_reg <= 1'b1;
      alert_output_one_oe_reg <= 1'b0;
    end
    else
    begin
      alert_output_one_n_reg <= 1'b0;
      alert_output_one_oe_reg <= (output_pin_one_function != `PIN_FN_TRIG)
        & ((health_flag_reg & alert_mask_reg[`ALERT_HEALTH_BIT])
        | (oc_flag_reg & alert_mask_reg[`ALERT_OC_BIT])
        | (ov_flag_reg & alert_mask_reg[`ALERT_OV_BIT]));
    end
  end

  // read mux: whole register captured at once, length zero if unmapped
  always @*
  begin
    snap = 64'h0;
    snap_len = 4'h0;
    case (cmd_code)
      `OFF_MFR_STATUS:
      begin
        snap = {61'h0, last_shutdown_reason_reg};
        snap_len = 4'h1;
      end
      `OFF_ENERGY_READOUT:
      begin
        // count, wraps, top 16 of energy
        snap = {16'h0, sample_count_reg, energy_wrap_total_reg, energy_reg[23:8]};
        snap_len = 4'h6;
      end
      `OFF_INPUT_VOLTAGE:
      begin
        snap = {52'h0, ch_avg[11:0]};
        snap_len = 4'h2;
      end
      `OFF_OUTPUT_VOLTAGE:
      begin
        snap = {52'h0, ch_avg[23:12]};
        snap_len = 4'h2;
      end
      `OFF_OUTPUT_CURRENT:
      begin
        snap = {52'h0, ch_avg[35:24]};
        snap_len = 4'h2;
      end
      `OFF_TEMPERATURE:
      begin
        snap = {52'h0, ch_avg[47:36]};
        snap_len = 4'h2;
      end
      `OFF_INPUT_POWER:
      begin
        // top 16 bits of the averaged product
        snap = {48'h0, pw_avg_val[23:8]};
        snap_len = 4'h2;
      end
      `OFF_PROTOCOL_REV:
      begin
        snap = {56'h0, `PROTOCOL_REV_VALUE};
        snap_len = 4'h1;
      end
      `OFF_MAKER_STRING:
      begin
        snap = {32'h0, MAKER_ID};
        snap_len = 4'h4;
      end
      `OFF_MODEL_STRING:
      begin
        snap = {8'h0, MODEL_ID};
        snap_len = 4'h7;
      end
      `OFF_HW_REV_STRING:
      begin
        snap = {48'h0, HW_REV_ID};
        snap_len = 4'h2;
      end
      `OFF_PEAK_CURRENT:
      begin
        snap = {52'h0, peak_current_reg};
        snap_len = 4'h2;
      end
      `OFF_PEAK_INPUT_VOLTAGE:
      begin
        snap = {52'h0, peak_input_voltage_reg};
        snap_len = 4'h2;
      end
      `OFF_PEAK_OUTPUT_VOLTAGE:
      begin
        snap = {52'h0, peak_output_voltage_reg};
        snap_len = 4'h2;
      end
      `OFF_RUN_CONTROL:
      begin
        snap = {63'h0, run_reg};
        snap_len = 4'h1;
      end
      `OFF_MONITOR_CONFIG:
      begin
        snap = {48'h0, config_reg};
        snap_len = 4'h2;
      end
      `OFF_ALERT_ONE_MASK:
      begin
        snap = {48'h0, alert_mask_reg};
        snap_len = 4'h2;
      end
      default:
      begin
        snap = 64'h0;
        snap_len = 4'h0;
      end
    endcase
  end

  // capture on start, hand out low byte first, shift on each next
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_shift_reg <= 64'h0;
      rd_data_reg <= 8'h00;
      rd_len_reg <= 4'h0;
    end
    else if (rd_start)
    begin
      rd_shift_reg <= snap;
      rd_data_reg <= snap[7:0];
      rd_len_reg <= snap_len;
    end
    else if (rd_next)
    begin
      rd_shift_reg <= {8'h00, rd_shift_reg[63:8]};
      rd_data_reg <= rd_shift_reg[15:8];
    end
  end

endmodule

// ---- hw/power_monitor_regs.vh ----
/*
  Command codes, field positions, reset values and write masks of the
  power monitor register bank.
  Assumes a link layer that has already turned bus traffic into command codes.
*/
`ifndef POWER_MONITOR_REGS_VH
`define POWER_MONITOR_REGS_VH

// command codes
`define OFF_MFR_STATUS 8'h80
`define OFF_ENERGY_READOUT 8'h86
`define OFF_INPUT_VOLTAGE 8'h88
`define OFF_OUTPUT_VOLTAGE 8'h8B
`define OFF_OUTPUT_CURRENT 8'h8C
`define OFF_TEMPERATURE 8'h8D
`define OFF_INPUT_POWER 8'h97
`define OFF_PROTOCOL_REV 8'h98
`define OFF_MAKER_STRING 8'h99
`define OFF_MODEL_STRING 8'h9A
`define OFF_HW_REV_STRING 8'h9B
`define OFF_PEAK_CURRENT 8'hD0
`define OFF_PEAK_INPUT_VOLTAGE 8'hD1
`define OFF_PEAK_OUTPUT_VOLTAGE 8'hD2
`define OFF_RUN_CONTROL 8'hD3
`define OFF_MONITOR_CONFIG 8'hD4
`define OFF_ALERT_ONE_MASK 8'hD5

// shutdown reason codes
`define CAUSE_NONE 3'h0
`define CAUSE_OVERTEMP 3'h1
`define CAUSE_OVERCURRENT 3'h2
`define CAUSE_HEALTH 3'h3
`define CAUSE_UNDERVOLT 3'h4
`define CAUSE_OVERVOLT 3'h6

// monitor configuration fields
`define CFG_PW_AVG_HI 13
`define CFG_PW_AVG_LO 11
`define CFG_VA_AVG_HI 10
`define CFG_VA_AVG_LO 8
`define CFG_MODE_BIT 4
`define CFG_TEMP_EN_BIT 3
`define CFG_VIN_ON_BIT 2
`define CFG_VOUT_ON_BIT 1
`define CFG_RESET 16'h0714
`define CFG_WRITE_MASK 16'h3F1E

// run control, alert mask, revision
`define RUN_RESET 1'b1
`define ALERT_HEALTH_BIT 15
`define ALERT_OC_BIT 14
`define ALERT_OV_BIT 13
`define ALERT_RESET 16'h0000
`define ALERT_WRITE_MASK 16'hFFFE
`define PROTOCOL_REV_VALUE 8'h33
`define PIN_FN_TRIG 2'h2

`endif

// ---- hw/sample_averager.v ----
/*
  Power-of-two sample averager: sums 2^sel samples, then presents the mean.
  Assumes in_valid is a one-cycle pulse on clk and sel is stable within a run.
*/
`timescale 1ns/10ps
module sample_averager #(
  parameter W = 12
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // control
  input wire restart,
  input wire [2:0] sel,
  // samples in
  input wire in_valid,
  input wire [W-1:0] in_data,
  // mean out
  output reg [W-1:0] avg_reg,
  output reg done_reg
);

  reg [W+6:0] acc_reg;
  reg [6:0] cnt_reg;
  wire [W+6:0] sum;
  wire [W+6:0] mean;
  wire [6:0] last;

  assign sum = acc_reg + {7'h00, in_data};
  assign mean = sum >> sel;
  // 2^sel - 1 samples already summed means this one closes the window
  assign last = (7'h01 << sel) - 7'h01;

  // accumulate, and drop the sum at the window end so no carry builds up
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_reg <= {(W+7){1'b0}};
      cnt_reg <= 7'h00;
      avg_reg <= {W{1'b0}};
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (restart)
      begin
        acc_reg <= {(W+7){1'b0}};
        cnt_reg <= 7'h00;
      end
      else if (in_valid)
      begin
        if (cnt_reg == last)
        begin
          avg_reg <= mean[W-1:0];
          done_reg <= 1'b1;
          acc_reg <= {(W+7){1'b0}};
          cnt_reg <= 7'h00;
        end
        else
        begin
          acc_reg <= sum;
          cnt_reg <= cnt_reg + 7'h01;
        end
      end
    end
  end

endmodule
